// File: rtl/sbt_pkg.sv
/*
 * Package for the memory boundary-scan test access port: instruction codes,
 * controller states, register widths and reset values, shared pin carriers.
 * Assumes nothing of its surroundings.
 */
package sbt_pkg;
   localparam int IR_WIDTH  = 3;
   localparam int ID_WIDTH  = 32;
   localparam int BSR_WIDTH = 16;
   localparam int BSR_PINS  = 12;
   localparam int RESET_TMS_EDGES = 5;

   localparam logic [2:0] CODE_EXTEST   = 3'h0;
   localparam logic [2:0] CODE_IDCODE   = 3'h1;
   localparam logic [2:0] CODE_SAMPLE_Z = 3'h2;
   localparam logic [2:0] CODE_RESV_A   = 3'h3;
   localparam logic [2:0] CODE_SAMPLE   = 3'h4;
   localparam logic [2:0] CODE_PRIVATE  = 3'h5;
   localparam logic [2:0] CODE_RESV_B   = 3'h6;
   localparam logic [2:0] CODE_BYPASS   = 3'h7;

   localparam logic [2:0] IR_RESET_VAL   = CODE_IDCODE;
   localparam logic [1:0] IR_CAPTURE_VAL = 2'h1;
   // identification value is arbitrary
   localparam logic [31:0] ID_VALUE_DEFAULT = 32'h1234_5A5B;

   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
      ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
      ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
   } sbt_state_t;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } sbt_scan_in_t;

   typedef struct packed {
      logic tdo;
      logic tdo_oe;
   } sbt_scan_out_t;
endpackage

// File: rtl/sbt_sync.sv
/*
 * Two-flop synchroniser for one level from outside the system clock domain.
 * Assumes sys_clk_in is much faster than the signal changes.
 */
`timescale 1ns/1ps
module sbt_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   input  wire logic sys_clk_in,
   input  wire logic rst_in,
   input  wire logic d_in,
   output logic      q_out
);
   logic meta_reg;
   logic sync_reg;

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta_reg <= RESET_VAL;
         sync_reg <= RESET_VAL;
      end else begin
         meta_reg <= d_in;
         sync_reg <= meta_reg;
      end
   end

   assign q_out = sync_reg;
endmodule

// File: rtl/sbt_fsm.sv
/*
 * Sixteen-state test access port controller, advanced once per test-clock
 * rising edge seen by the system clock. Assumes tms is already synchronised.
 */
`timescale 1ns/1ps
module sbt_fsm (
   input  wire logic               sys_clk_in,
   input  wire logic               rst_in,
   input  wire logic               step_in,
   input  wire logic               tms_in,
   output sbt_pkg::sbt_state_t     state_out
);
   import sbt_pkg::*;

   sbt_state_t state_reg;
   sbt_state_t state_next;

   always_comb begin
      case (state_reg)
         ST_RESET:    state_next = tms_in ? ST_RESET    : ST_IDLE;
         ST_IDLE:     state_next = tms_in ? ST_SEL_DR   : ST_IDLE;
         ST_SEL_DR:   state_next = tms_in ? ST_SEL_IR   : ST_CAP_DR;
         ST_CAP_DR:   state_next = tms_in ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_SHIFT_DR: state_next = tms_in ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_EXIT1_DR: state_next = tms_in ? ST_UPD_DR   : ST_PAUSE_DR;
         ST_PAUSE_DR: state_next = tms_in ? ST_EXIT2_DR : ST_PAUSE_DR;
         ST_EXIT2_DR: state_next = tms_in ? ST_UPD_DR   : ST_SHIFT_DR;
         ST_UPD_DR:   state_next = tms_in ? ST_SEL_DR   : ST_IDLE;
         ST_SEL_IR:   state_next = tms_in ? ST_RESET    : ST_CAP_IR;
         ST_CAP_IR:   state_next = tms_in ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_SHIFT_IR: state_next = tms_in ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_EXIT1_IR: state_next = tms_in ? ST_UPD_IR   : ST_PAUSE_IR;
         ST_PAUSE_IR: state_next = tms_in ? ST_EXIT2_IR : ST_PAUSE_IR;
         ST_EXIT2_IR: state_next = tms_in ? ST_UPD_IR   : ST_SHIFT_IR;
         ST_UPD_IR:   state_next = tms_in ? ST_SEL_DR   : ST_IDLE;
         default:     state_next = ST_RESET;
      endcase
   end

   // power-up lands in test-logic-reset
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= ST_RESET;
      end else if (step_in) begin
         state_reg <= state_next;
      end
   end

   assign state_out = state_reg;
endmodule

// File: rtl/sbt_tap.sv
/*
 * Boundary-scan test access port of a synchronous burst memory: pin
 * synchronisers, controller, instruction, bypass, identification and
 * boundary scan registers, serial output and output-driver control.
 * Assumes the scan pins are asynchronous to sys_clk_in and the test clock
 * is at least eight system clocks per phase; pin pull-ups sit outside.
 */
`timescale 1ns/1ps

// Overview of operation
// [R1] five test-clock rises with mode select high always reach test-logic-reset
// [R2] controller resets itself at power-up with no outside action
// [R3] shift on test-clock rise, serial out changes on following fall
// [R4] instruction register is three bits, loaded serially when selected
// [R5] instruction preset to identification code 001 at power-up and reset state
// [R6] capture-ir loads the two low instruction bits with 01
// [R7] shift-ir shifts new instruction in while old contents shift out
// [R8] new instruction takes effect only at update-ir
// [R9] bypass is one flip-flop between serial in and out
// [R10] boundary positions without a pin always capture one
// [R11] boundary instructions capture the ring, then shift in shift-dr
// [R12] identification instruction loads fixed 32-bit constant and shifts it out
// [R13] identification register shifts least significant bit first
// [R14] code 000 and all-zero register select external test via boundary path
// [R15] external test leaves inputs in control, outputs drive boundary cells
// [R16] external test output pins drive their cells; capture on test-clock rise
// [R17] code 100 samples input and io levels into the boundary register
// [R18] code 010 floats all outputs, captures ring, shifts boundary register
// [R19] code 111 selects bypass in shift-dr
// [R20] reserved codes 011 and 110 act as bypass
// [R21] surrounding logic holds memory inputs stable around capture edges
// [R22] undriven mode select and serial data read as one
// [R23] standard sixteen-state controller advances on each test-clock rise
// [R24] serial out driven only in shift-ir and shift-dr
module sbt_tap #(
   parameter logic [31:0] ID_VALUE = sbt_pkg::ID_VALUE_DEFAULT
) (
   input  wire logic                         sys_clk_in,
   input  wire logic                         rst_in,
   input  wire sbt_pkg::sbt_scan_in_t        scan_in,
   input  wire logic [sbt_pkg::BSR_PINS-1:0] ring_in,
   input  wire logic [sbt_pkg::BSR_PINS-1:0] core_out_in,
   input  wire logic [sbt_pkg::BSR_PINS-1:0] core_oe_in,
   output sbt_pkg::sbt_scan_out_t            scan_out,
   output logic [sbt_pkg::BSR_PINS-1:0]      pin_out,
   output logic [sbt_pkg::BSR_PINS-1:0]      pin_oe_out,
   output logic [sbt_pkg::IR_WIDTH-1:0]      instr_out,
   output sbt_pkg::sbt_state_t               state_out
);
   import sbt_pkg::*;

   default clocking cb_sys @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);

   logic                tck_s;
   logic                tms_s;
   logic                tdi_s;
   logic                tck_d_reg;
   logic                tck_rise;
   logic                tck_fall;
   sbt_state_t          state;
   logic [IR_WIDTH-1:0] ir_shift_reg;
   logic [IR_WIDTH-1:0] instruction_reg;
   logic                bypass_reg;
   logic [ID_WIDTH-1:0] identification_reg;
   logic [BSR_WIDTH-1:0] bsr_reg;
   logic [BSR_WIDTH-1:0] bsr_capture;
   logic [BSR_PINS-1:0] bsr_update_reg;
   logic                tdo_reg;
   logic                tdo_oe_reg;
   logic                sel_bsr;
   logic                sel_id;
   logic                sel_bypass;
   logic                in_shift_dr;
   logic                in_shift_ir;
   logic                dr_serial;
   logic                tdo_next;
   logic                extest_on;
   logic                float_on;

   // pull-ups give a reset value of one on mode select and serial data
   sbt_sync #(.RESET_VAL(1'b0)) u_sync_tck (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .d_in       (scan_in.tck),
      .q_out      (tck_s)
   );
   sbt_sync #(.RESET_VAL(1'b1)) u_sync_tms (  // R22
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .d_in       (scan_in.tms),
      .q_out      (tms_s)
   );
   sbt_sync #(.RESET_VAL(1'b1)) u_sync_tdi (  // R22
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .d_in       (scan_in.tdi),
      .q_out      (tdi_s)
   );

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tck_d_reg <= 1'b0;
      end else begin
         tck_d_reg <= tck_s;
      end
   end

   assign tck_rise = tck_s & ~tck_d_reg;
   assign tck_fall = ~tck_s & tck_d_reg;

   sbt_fsm u_fsm (  // R23 R1 R2
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .step_in    (tck_rise),
      .tms_in     (tms_s),
      .state_out  (state)
   );

   // instruction decode, from the active instruction only
   assign sel_bsr    = (instruction_reg == CODE_EXTEST) |  // R14
                       (instruction_reg == CODE_SAMPLE_Z) |  // R18
                       (instruction_reg == CODE_SAMPLE);  // R17
   assign sel_id     = (instruction_reg == CODE_IDCODE);  // R12
   assign sel_bypass = ~sel_bsr & ~sel_id;  // R19 R20
   assign extest_on  = (instruction_reg == CODE_EXTEST);  // R15
   assign float_on   = (instruction_reg == CODE_SAMPLE_Z);  // R18
   assign in_shift_dr = (state == ST_SHIFT_DR);
   assign in_shift_ir = (state == ST_SHIFT_IR);

   // instruction shift stage and active instruction
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ir_shift_reg    <= IR_RESET_VAL;
         instruction_reg <= IR_RESET_VAL;  // R5
      end else if (state == ST_RESET) begin
         ir_shift_reg    <= IR_RESET_VAL;
         instruction_reg <= IR_RESET_VAL;  // R5
      end else if (tck_rise) begin
         if (state == ST_CAP_IR) begin
            ir_shift_reg <= {ir_shift_reg[IR_WIDTH-1:2], IR_CAPTURE_VAL};  // R6
         end else if (in_shift_ir) begin
            ir_shift_reg <= {tdi_s, ir_shift_reg[IR_WIDTH-1:1]};  // R4 R7
         end
      end else if (tck_fall && state == ST_UPD_IR) begin
         instruction_reg <= ir_shift_reg;  // R8
      end
   end

   // bypass bit
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         bypass_reg <= 1'b0;
      end else if (tck_rise && sel_bypass) begin
         if (state == ST_CAP_DR) begin
            bypass_reg <= 1'b0;
         end else if (in_shift_dr) begin
            bypass_reg <= tdi_s;  // R9
         end
      end
   end

   // identification register, lsb leaves first
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         identification_reg <= '0;
      end else if (tck_rise && sel_id) begin
         if (state == ST_CAP_DR) begin
            identification_reg <= ID_VALUE;  // R12
         end else if (in_shift_dr) begin
            identification_reg <= {tdi_s, identification_reg[ID_WIDTH-1:1]};  // R13
         end
      end
   end

   // boundary capture: pin cells from the ring, spare cells read one
   generate
      for (genvar i = 0; i < BSR_WIDTH; i++) begin : g_cell
         if (i < BSR_PINS) begin : g_pin
            assign bsr_capture[i] = ring_in[i];  // R11 R16
         end else begin : g_spare
            assign bsr_capture[i] = 1'b1;  // R10
         end
      end
   endgenerate

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         bsr_reg <= '0;
      end else if (tck_rise && sel_bsr) begin
         if (state == ST_CAP_DR) begin
            bsr_reg <= bsr_capture;  // R11 R17 R18
         end else if (in_shift_dr) begin
            bsr_reg <= {tdi_s, bsr_reg[BSR_WIDTH-1:1]};  // R11
         end
      end
   end

   // update stage drives the pins during external test
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         bsr_update_reg <= '0;
      end else if (tck_fall && state == ST_UPD_DR && sel_bsr) begin
         bsr_update_reg <= bsr_reg[BSR_PINS-1:0];
      end
   end

   assign pin_out    = extest_on ? bsr_update_reg : core_out_in;  // R15 R16
   assign pin_oe_out = float_on ? '0 : (extest_on ? '1 : core_oe_in);  // R18 R15

   // serial output changes on the test-clock fall
   assign dr_serial = sel_bsr ? bsr_reg[0] : (sel_id ? identification_reg[0] : bypass_reg);
   assign tdo_next  = in_shift_ir ? ir_shift_reg[0] : dr_serial;

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tdo_reg    <= 1'b0;
         tdo_oe_reg <= 1'b0;
      end else if (tck_fall) begin
         tdo_reg    <= tdo_next;  // R3
         tdo_oe_reg <= in_shift_ir | in_shift_dr;  // R24
      end
   end

   assign scan_out.tdo    = tdo_reg;
   assign scan_out.tdo_oe = tdo_oe_reg;
   assign instr_out       = instruction_reg;
   assign state_out       = state;

   // assertions
   int unsigned tms_high_cnt;
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tms_high_cnt <= 0;
      end else if (tck_rise) begin
         tms_high_cnt <= tms_s ? ((tms_high_cnt < 8) ? tms_high_cnt + 1 : tms_high_cnt) : 0;
      end
   end

   sequence s_ir_capture;
      tck_rise && state == ST_CAP_IR;
   endsequence

   a_five_tms_reset: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R1
      tms_high_cnt >= RESET_TMS_EDGES |-> state == ST_RESET)
      else $error("five high mode select edges did not reach reset");
   a_reset_preset_ir: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R5
      state == ST_RESET |=> instruction_reg == CODE_IDCODE)
      else $error("instruction not preset to identification");
   a_capture_ir_bits: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R6
      s_ir_capture |=> ir_shift_reg[1:0] == IR_CAPTURE_VAL)
      else $error("capture-ir pattern wrong");
   a_ir_hold_update: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R8
      state != ST_UPD_IR && state != ST_RESET |=> $stable(instruction_reg))
      else $error("instruction changed outside update");
   a_tdo_on_fall: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R3
      !$past(tck_fall) |-> $stable(tdo_reg))
      else $error("serial out changed off a falling edge");
   a_tdo_drive_win: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R24
      tck_fall && !in_shift_ir && !in_shift_dr |=> !scan_out.tdo_oe)
      else $error("serial out driven outside shift");
   a_id_capture_val: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R12
      tck_rise && sel_id && state == ST_CAP_DR |=> identification_reg == ID_VALUE)
      else $error("identification capture wrong");
   a_spare_cells_one: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R10
      tck_rise && sel_bsr && state == ST_CAP_DR |=> &bsr_reg[BSR_WIDTH-1:BSR_PINS])
      else $error("spare boundary cells not one");
   a_sample_z_float: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R18
      instruction_reg == CODE_SAMPLE_Z |-> pin_oe_out == '0)
      else $error("outputs not floated");
   a_bypass_path: assert property (@(posedge sys_clk_in) disable iff (rst_in)  // R20
      in_shift_dr && (instruction_reg == CODE_RESV_A || instruction_reg == CODE_RESV_B)
      && tck_rise |=> bypass_reg == $past(tdi_s))
      else $error("reserved code not acting as bypass");

   // per-step sequences for the data and instruction paths
   sequence s_dr_capture(sel);
      tck_rise && state == ST_CAP_DR && sel;
   endsequence
   sequence s_dr_shift(sel);
      tck_rise && in_shift_dr && sel;
   endsequence
   sequence s_dr_present(sel);
      tck_fall && in_shift_dr && sel;
   endsequence
   sequence s_ir_update;
      tck_fall && state == ST_UPD_IR;
   endsequence
   sequence s_ir_shift;
      tck_rise && in_shift_ir;
   endsequence

   a_ir_update_load: assert property (  // R8
      s_ir_update |=> instruction_reg == $past(ir_shift_reg))
      else $error("update-ir load wrong");
   a_ir_shift_in: assert property (  // R7
      s_ir_shift |=> ir_shift_reg[IR_WIDTH-1] == $past(tdi_s))
      else $error("instruction shift input wrong");
   a_ir_shift_down: assert property (  // R4
      s_ir_shift |=> ir_shift_reg[IR_WIDTH-2:0] == $past(ir_shift_reg[IR_WIDTH-1:1]))
      else $error("instruction shift order wrong");
   a_reset_ir_shift: assert property (  // R5
      state == ST_RESET |=> ir_shift_reg == IR_RESET_VAL)
      else $error("instruction shift stage not preset");
   a_ir_tdo_path: assert property (  // R7
      tck_fall && in_shift_ir |=> scan_out.tdo == $past(ir_shift_reg[0]))
      else $error("instruction bit not on serial out");
   a_id_shift_down: assert property (  // R13
      s_dr_shift(sel_id) |=>
      identification_reg[ID_WIDTH-2:0] == $past(identification_reg[ID_WIDTH-1:1]))
      else $error("identification shift order wrong");
   a_id_first_bit: assert property (  // R13
      s_dr_present(sel_id) |=> scan_out.tdo == $past(identification_reg[0]))
      else $error("identification low bit not on serial out");
   a_bsr_capture_ring: assert property (  // R11 R17
      s_dr_capture(sel_bsr) |=> bsr_reg[BSR_PINS-1:0] == $past(ring_in))
      else $error("ring not captured");
   a_bsr_shift_in: assert property (  // R11
      s_dr_shift(sel_bsr) |=> bsr_reg[BSR_WIDTH-1] == $past(tdi_s))
      else $error("boundary shift input wrong");
   a_bsr_serial_out: assert property (  // R11
      s_dr_present(sel_bsr) |=> scan_out.tdo == $past(bsr_reg[0]))
      else $error("boundary bit not on serial out");
   a_bypass_capture: assert property (  // R9
      s_dr_capture(sel_bypass) |=> !bypass_reg)
      else $error("bypass capture not zero");
   a_bypass_one_bit: assert property (  // R19
      s_dr_shift(instruction_reg == CODE_BYPASS) |=> bypass_reg == $past(tdi_s))
      else $error("bypass shift wrong");
   a_bypass_serial: assert property (  // R9
      s_dr_present(sel_bypass) |=> scan_out.tdo == $past(bypass_reg))
      else $error("bypass bit not on serial out");
   a_extest_pins: assert property (  // R15 R16
      extest_on |-> pin_out == bsr_update_reg && pin_oe_out == '1)
      else $error("external test pins wrong");
   a_core_pass: assert property (  // R15
      !extest_on |-> pin_out == core_out_in)
      else $error("core data not on pins");
   a_update_stage: assert property (  // R16
      tck_fall && state == ST_UPD_DR && sel_bsr |=>
      bsr_update_reg == $past(bsr_reg[BSR_PINS-1:0]))
      else $error("update stage load wrong");
   a_fsm_hold: assert property (  // R23
      !tck_rise |=> $stable(state))
      else $error("state moved without a test-clock rise");
   a_tms_low_idle: assert property (  // R23
      tck_rise && state == ST_RESET && !tms_s |=> state == ST_IDLE)
      else $error("reset with mode select low did not reach idle");
   a_tdo_oe_shift: assert property (  // R24
      tck_fall && (in_shift_ir || in_shift_dr) |=> scan_out.tdo_oe)
      else $error("serial out not driven in shift");
endmodule

// File: tb/sbt_ctrl_model.sv
/*
 * Behavioural scan controller that drives the test access port pins.
 * Assumes the caller sequences the controller from run-test/idle; the test
 * clock stands low between calls and runs at a 64 ns period inside them.
 */
`timescale 1ns/1ps
module sbt_ctrl_model (
   input  wire logic tdo_in,
   input  wire logic tdo_oe_in,
   output logic      tck_out,
   output logic      tms_out,
   output logic      tdi_out
);
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b1;
   end

   // mode and data change at the fall, serial out sampled before the rise
   task automatic tick(input logic tms_v, input logic tdi_v, output logic tdo_v,
                       output logic oe_v);
      tms_out = tms_v;
      tdi_out = tdi_v;
      #32;
      // undriven serial out shows the inverse so a stale bit cannot pass
      tdo_v   = tdo_oe_in ? tdo_in : ~tdo_in;
      oe_v    = tdo_oe_in;
      tck_out = 1'b1;
      #32;
      tck_out = 1'b0;
   endtask

   // data line not in use toggles so a stale value cannot pass
   task automatic step(input logic tms_v);
      logic d;
      logic e;
      tick(tms_v, ~tdi_out, d, e);
   endtask

   task automatic reset5();
      repeat (5) step(1'b1);
   endtask

   // from idle into shift, n bits lsb first, ends in exit1
   task automatic scan(input logic ir, input logic [39:0] din, input int n,
                       output logic [39:0] dout, output logic oe_all);
      logic d;
      logic e;
      step(1'b1);
      if (ir) begin
         step(1'b1);
      end
      step(1'b0);
      step(1'b0);
      dout   = '0;
      oe_all = 1'b1;
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], d, e);
         dout[i] = d;
         oe_all  = oe_all & e;
      end
   endtask

   // exit1 to update to idle, enable seen in exit1 returned
   task automatic update(output logic oe_v);
      logic d;
      tick(1'b1, ~tdi_out, d, oe_v);
      step(1'b0);
   endtask
endmodule

// File: tb/sbt_tap_tb.sv
/*
 * Self-checking bench for the boundary-scan access port.
 * Assumes the scan controller model drives the scan pins.
 */
`timescale 1ns/1ps
module sbt_tap_tb;
   import sbt_pkg::*;
   // identification value is arbitrary
   localparam logic [31:0] ID_TB = 32'hC3A5_0F96;
   logic                sys_clk_in;
   logic                rst_in;
   sbt_scan_in_t        scan_in;
   sbt_scan_out_t       scan_out;
   logic [BSR_PINS-1:0] ring_in;
   logic [BSR_PINS-1:0] core_out_in;
   logic [BSR_PINS-1:0] core_oe_in;
   logic [BSR_PINS-1:0] pin_out;
   logic [BSR_PINS-1:0] pin_oe_out;
   logic [IR_WIDTH-1:0] instr_out;
   sbt_state_t          state_out;
   logic [15:0]         lfsr;
   logic [39:0]         din;
   logic [39:0]         dout;
   logic [39:0]         rv;
   logic                oe_a;
   logic                oe_b;
   int                  fail_count;
   int                  comparisons;

   sbt_tap #(.ID_VALUE(ID_TB)) sbt_tap_inst (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in), .scan_in(scan_in), .ring_in(ring_in),
      .core_out_in(core_out_in), .core_oe_in(core_oe_in), .scan_out(scan_out),
      .pin_out(pin_out), .pin_oe_out(pin_oe_out), .instr_out(instr_out),
      .state_out(state_out));
   sbt_ctrl_model sbt_ctrl_model_inst (
      .tdo_in(scan_out.tdo), .tdo_oe_in(scan_out.tdo_oe), .tck_out(scan_in.tck),
      .tms_out(scan_in.tms), .tdi_out(scan_in.tdi));

   initial sys_clk_in = 1'b0;
   always #2 sys_clk_in = ~sys_clk_in;

   function automatic logic [15:0] lfsr_next(input logic [15:0] l);
      return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
   endfunction

   task automatic draw(output logic [39:0] v);
      for (int i = 0; i < 3; i++) begin
         lfsr = lfsr_next(lfsr);
         v    = {v[23:0], lfsr};
      end
   endtask

   // serial image expected from a data scan under each instruction
   function automatic logic [39:0] dr_expect(input logic [2:0] code, input logic [11:0] ring,
                                             input logic [39:0] t);
      case (code)
         CODE_IDCODE: return {7'h0, t[0], ID_TB};
         CODE_EXTEST, CODE_SAMPLE_Z, CODE_SAMPLE: return {23'h0, t[0], 4'hF, ring};
         default: return {23'h0, t[15:0], 1'b0};
      endcase
   endfunction

   task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic ir_load(input logic [2:0] code);
      logic [2:0] old;
      old = instr_out;
      sbt_ctrl_model_inst.scan(1'b1, {37'h0, code}, 3, dout, oe_a);
      check(dout[1:0], IR_CAPTURE_VAL, "instruction capture");
      check(instr_out, old, "instruction before update");
      sbt_ctrl_model_inst.update(oe_b);
      check(instr_out, code, "instruction after update");
      $display("test instruction load done");
   endtask

   task automatic dr_test(input logic [2:0] code);
      int n;
      n = (code == CODE_IDCODE) ? 33 : 17;
      draw(din);
      din = din & ((40'h1 << n) - 40'h1);
      draw(rv);
      @(negedge sys_clk_in);
      ring_in     = rv[11:0];
      core_out_in = rv[23:12];
      core_oe_in  = rv[35:24];
      sbt_ctrl_model_inst.scan(1'b0, din, n, dout, oe_a);
      check(dout, dr_expect(code, ring_in, din), "data scan");
      check(oe_a, 1'b1, "serial out enabled in shift");
      sbt_ctrl_model_inst.update(oe_b);
      check(oe_b, 1'b0, "serial out released in exit1");
      check(state_out, ST_IDLE, "back in idle");
      check(pin_oe_out, code == CODE_EXTEST ? 12'hFFF : code == CODE_SAMPLE_Z ? 12'h000 :
            core_oe_in, "pin enables");
      check(pin_out, code == CODE_EXTEST ? din[12:1] : core_out_in, "pin data");
      $display("test code %0d done", code);
   endtask

   initial begin
      repeat (100000) @(posedge sys_clk_in);
      fail_count++;
      $display("mismatch at %0t: run did not finish", $time);
      stop_test();
   end

   initial begin
      rst_in      = 1'b1;
      lfsr        = 16'h6EE4;
      draw(rv);
      ring_in     = rv[11:0];
      core_out_in = rv[23:12];
      core_oe_in  = rv[35:24];
      fail_count  = 0;
      comparisons = 0;
      repeat (8) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      rst_in = 1'b0;
      repeat (4) @(negedge sys_clk_in);
      check(state_out, ST_RESET, "power-up state");
      check(instr_out, CODE_IDCODE, "power-up instruction");
      $display("test power-up done");
      sbt_ctrl_model_inst.step(1'b0);
      // identification straight from the power-up instruction
      dr_test(CODE_IDCODE);
      for (int c = 0; c < 8; c++) begin
         ir_load(c[2:0]);
         dr_test(c[2:0]);
      end
      // five mode-select ones from shift-dr, not four, reach reset
      sbt_ctrl_model_inst.step(1'b1);
      sbt_ctrl_model_inst.step(1'b0);
      sbt_ctrl_model_inst.step(1'b0);
      check(state_out, ST_SHIFT_DR, "shift-dr reached");
      repeat (4) sbt_ctrl_model_inst.step(1'b1);
      check(state_out == ST_RESET, 1'b0, "reset after four");
      sbt_ctrl_model_inst.step(1'b1);
      check(state_out, ST_RESET, "reset after five");
      check(instr_out, CODE_IDCODE, "instruction preset by reset");
      $display("test tms reset done");
      sbt_ctrl_model_inst.step(1'b0);
      ir_load(CODE_BYPASS);
      @(negedge sys_clk_in);
      rst_in = 1'b1;
      repeat (2) @(negedge sys_clk_in);
      check(state_out, ST_RESET, "second reset state");
      check(instr_out, CODE_IDCODE, "second reset instruction");
      $display("test second reset done");
      rst_in = 1'b0;
      repeat (4) @(negedge sys_clk_in);
      sbt_ctrl_model_inst.reset5();
      sbt_ctrl_model_inst.step(1'b0);
      dr_test(CODE_IDCODE);
      stop_test();
   end
endmodule
